// file: scc_regs.sv
// scc_regs: identification, local-memory size and control registers of the core.
// assumes the core drives one transfer per cycle, synchronous to CLK.
// Notes on behaviour
// - identification word: implementer, major, architecture, part, minor fields, read only.
// - register 0 read returns identification word unless secondary opcode equals 2.
// - register 0 read with secondary opcode 2 returns local-memory size word.
// - data memory size field is a 5-bit doubling code up to 64MB.
// - instruction memory size field uses the same doubling code.
// - both size fields read 8KB code; only valid codes allowed.
// - both memory-missing flags read 0 since memories are present.
// - compact-load disable bit stops PC loads setting compact state; reset clears.
// - vector bit selects low or high vectors; reset value from strap.
// - instruction memory enable routes fixed region locally; reset from strap.
// - endianness bit: 0 little, 1 big; reset 0.
// - write-buffer enable buffers fixed bufferable stores; reset clears.
// - control bits 31:16 and 14 read zero; software writes zero.
// - control bits 11:8 and 6:4 read one; software writes one.
// - registers 2-6, 8-12, 14 reserved; only 0, 1, 7, 13 defined.
// - control bit 2 enables data memory; reset from memory strap.
// - control bit 1 enables alignment fault checking; reset clears.
`timescale 1ns/100ps

module scc_regs
  import scc_pkg::*;
#(
  parameter logic [4:0] DATA_MEM_SIZE  = SCC_SIZE_8K,
  parameter logic [4:0] INSTR_MEM_SIZE = SCC_SIZE_8K
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // straps
  input  wire logic        VECTOR_STRAP_INPUT,
  input  wire logic        LOCAL_MEMORY_STRAP_INPUT,
  // coprocessor transfer from the core
  input  wire logic        CP_READ,
  input  wire logic        CP_WRITE,
  input  wire logic [3:0]  CP_CRN,
  input  wire logic [2:0]  CP_OP2,
  input  wire logic [31:0] CP_WDATA,
  output logic      [31:0] CP_RDATA,
  output logic             CP_RVALID,
  // control outputs
  output logic             COMPACT_LOAD_DISABLE,
  output logic             HIGH_VECTORS,
  output logic             INSTR_MEM_ENABLE,
  output logic             BIG_ENDIAN,
  output logic             WRITE_BUFFER_ENABLE,
  output logic             DATA_MEM_ENABLE,
  output logic             ALIGN_CHECK_ENABLE
);

  // width of one size code, taken from the parameter
  localparam int SIZE_W = $bits(DATA_MEM_SIZE);

  // fixed identification word; field values are arbitrary
  // implementer, major, architecture, part and minor from top to bottom
  localparam logic [31:0] ID_WORD = {SCC_ID_IMPL,
                                     SCC_ID_MAJOR,
                                     SCC_ID_ARCH,
                                     SCC_ID_PART,
                                     SCC_ID_MINOR};

  // reset tracking and strap capture
  logic              in_reset;
  logic              strap_vec;
  logic              strap_mem;

  // transfer decode
  logic              sel_id;
  logic              sel_size;
  logic              sel_ctrl;
  logic              sel_none;
  logic              ctrl_wr;

  // read sources
  logic [SIZE_W-1:0] data_size_code;
  logic [SIZE_W-1:0] instr_size_code;
  logic              data_missing;
  logic              instr_missing;
  logic [31:0]       size_word;
  logic [31:0]       ctrl_word;
  logic [31:0]       next_rdata;
  logic              next_rvalid;

  // out-of-range size parameters fall back to no memory, never an undecodable code
  always_comb begin
    data_size_code = '0;
    if (DATA_MEM_SIZE <= SCC_SIZE_MAX) begin
      data_size_code = DATA_MEM_SIZE;
    end
  end

  always_comb begin
    instr_size_code = '0;
    if (INSTR_MEM_SIZE <= SCC_SIZE_MAX) begin
      instr_size_code = INSTR_MEM_SIZE;
    end
  end

  // a zero size code means that memory is not fitted
  always_comb begin
    data_missing  = (data_size_code == '0);
    instr_missing = (instr_size_code == '0);
  end

  // every bit outside the four fields reads zero
  always_comb begin
    size_word                          = '0;
    size_word[SCC_DSIZE_LSB +: SIZE_W] = data_size_code;
    size_word[SCC_ISIZE_LSB +: SIZE_W] = instr_size_code;
    // flags follow the codes, so with both memories fitted they read zero
    size_word[SCC_DMISS_BIT]           = data_missing;
    size_word[SCC_IMISS_BIT]           = instr_missing;
  end

  // only numbers 0 and 1 are backed; 7 and 13 are decoded in this block but read zero
  always_comb begin
    sel_id   = 1'b0;
    sel_size = 1'b0;
    sel_ctrl = 1'b0;
    sel_none = 1'b0;
    unique case (CP_CRN)
      // number 0 carries two words, chosen by the secondary opcode
      SCC_CRN_ID: begin
        if (CP_OP2 == SCC_OP2_SIZE) begin
          sel_size = 1'b1;
        end else begin
          sel_id = 1'b1;
        end
      end
      // number 1 ignores the secondary opcode
      SCC_CRN_CTRL: begin
        sel_ctrl = 1'b1;
      end
      // core control is handled elsewhere, so it reads zero here
      SCC_CRN_CORE: begin
        sel_none = 1'b1;
      end
      // trace identifier is handled elsewhere, so it reads zero here
      SCC_CRN_TRC: begin
        sel_none = 1'b1;
      end
      default: begin
        sel_none = 1'b1;
      end
    endcase
  end

  // writes to any other number are dropped
  assign ctrl_wr = CP_WRITE && sel_ctrl;

  // every read is answered exactly one cycle later
  always_comb begin
    next_rvalid = CP_READ;
  end

  // straps cannot load an async-reset flop directly, so they are captured on edges in reset
  // in_reset stays high for one edge after release so that edge can load them
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      in_reset <= 1'b1;
    end else begin
      in_reset <= 1'b0;
    end
  end

  // straps must be stable in reset; a change after release is not seen
  // vector strap
  always_ff @(posedge CLK) begin
    if (RST || in_reset) begin
      strap_vec <= VECTOR_STRAP_INPUT;
    end
  end

  // memory strap, shared by both memory enables
  always_ff @(posedge CLK) begin
    if (RST || in_reset) begin
      strap_mem <= LOCAL_MEMORY_STRAP_INPUT;
    end
  end

  // plain control bits: cleared by reset, loaded by a control write
  // compact-load disable
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      COMPACT_LOAD_DISABLE <= 1'b0;
    end else if (ctrl_wr) begin
      COMPACT_LOAD_DISABLE <= CP_WDATA[SCC_CB_CLD];
    end
  end

  // endianness
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      BIG_ENDIAN <= 1'b0;
    end else if (ctrl_wr) begin
      BIG_ENDIAN <= CP_WDATA[SCC_CB_BIG];
    end
  end

  // write buffer enable
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      WRITE_BUFFER_ENABLE <= 1'b0;
    end else if (ctrl_wr) begin
      WRITE_BUFFER_ENABLE <= CP_WDATA[SCC_CB_WBUF];
    end
  end

  // alignment fault checking
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ALIGN_CHECK_ENABLE <= 1'b0;
    end else if (ctrl_wr) begin
      ALIGN_CHECK_ENABLE <= CP_WDATA[SCC_CB_ALIGN];
    end
  end

  // strap-loaded bits take the captured strap on the first edge out of reset
  // a write in that same cycle loses to the strap
  // vector location
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      HIGH_VECTORS <= 1'b0;
    end else if (in_reset) begin
      HIGH_VECTORS <= strap_vec;
    end else if (ctrl_wr) begin
      HIGH_VECTORS <= CP_WDATA[SCC_CB_VEC];
    end
  end

  // instruction memory enable
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      INSTR_MEM_ENABLE <= 1'b0;
    end else if (in_reset) begin
      INSTR_MEM_ENABLE <= strap_mem;
    end else if (ctrl_wr) begin
      INSTR_MEM_ENABLE <= CP_WDATA[SCC_CB_IMEM];
    end
  end

  // data memory enable
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      DATA_MEM_ENABLE <= 1'b0;
    end else if (in_reset) begin
      DATA_MEM_ENABLE <= strap_mem;
    end else if (ctrl_wr) begin
      DATA_MEM_ENABLE <= CP_WDATA[SCC_CB_DMEM];
    end
  end

  // reserved-zero bits read zero and reserved-one bits read one, whatever was written
  always_comb begin
    ctrl_word               = SCC_RSV1_MASK;
    ctrl_word[SCC_CB_CLD]   = COMPACT_LOAD_DISABLE;
    ctrl_word[SCC_CB_VEC]   = HIGH_VECTORS;
    ctrl_word[SCC_CB_IMEM]  = INSTR_MEM_ENABLE;
    ctrl_word[SCC_CB_BIG]   = BIG_ENDIAN;
    ctrl_word[SCC_CB_WBUF]  = WRITE_BUFFER_ENABLE;
    ctrl_word[SCC_CB_DMEM]  = DATA_MEM_ENABLE;
    ctrl_word[SCC_CB_ALIGN] = ALIGN_CHECK_ENABLE;
  end

  // read mux; reserved and unbacked numbers read zero
  always_comb begin
    next_rdata = '0;
    if (sel_size) begin
      next_rdata = size_word;
    end else if (sel_id) begin
      next_rdata = ID_WORD;
    end else if (sel_ctrl) begin
      next_rdata = ctrl_word;
    end else if (sel_none) begin
      next_rdata = '0;
    end
  end

  // a read and a write in one cycle return the value before the write
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      // reset drops any answer in flight
      CP_RVALID <= 1'b0;
    end else begin
      CP_RVALID <= next_rvalid;
    end
  end

  // read data holds until the next read
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      // reads zero until the first read after reset
      CP_RDATA <= '0;
    end else if (CP_READ) begin
      CP_RDATA <= next_rdata;
    end
  end

endmodule : scc_regs

// file: scc_pkg.sv
// scc_pkg: constants for the system-control coprocessor register set.
// assumes a single core clock domain; shared by the register module only.
package scc_pkg;

  // coprocessor register numbers
  localparam logic [3:0] SCC_CRN_ID   = 4'h0;
  localparam logic [3:0] SCC_CRN_CTRL = 4'h1;
  localparam logic [3:0] SCC_CRN_CORE = 4'h7;
  localparam logic [3:0] SCC_CRN_TRC  = 4'hd;
  localparam logic [2:0] SCC_OP2_SIZE = 3'h2;

  // identification word fields (values arbitrary, not a real part)
  localparam logic [7:0]  SCC_ID_IMPL  = 8'h5a;
  localparam logic [3:0]  SCC_ID_MAJOR = 4'h0;
  localparam logic [3:0]  SCC_ID_ARCH  = 4'h0;
  localparam logic [11:0] SCC_ID_PART  = 12'h123;
  localparam logic [3:0]  SCC_ID_MINOR = 4'h0;

  // local-memory size word
  localparam logic [4:0] SCC_SIZE_8K   = 5'h04;
  localparam logic [4:0] SCC_SIZE_MAX  = 5'h11;
  localparam int         SCC_DSIZE_LSB = 18;
  localparam int         SCC_DMISS_BIT = 14;
  localparam int         SCC_ISIZE_LSB = 6;
  localparam int         SCC_IMISS_BIT = 2;

  // control register bit positions
  localparam int SCC_CB_CLD   = 15;
  localparam int SCC_CB_VEC   = 13;
  localparam int SCC_CB_IMEM  = 12;
  localparam int SCC_CB_BIG   = 7;
  localparam int SCC_CB_WBUF  = 3;
  localparam int SCC_CB_DMEM  = 2;
  localparam int SCC_CB_ALIGN = 1;
  localparam logic [31:0] SCC_RSV1_MASK = 32'h0000_0f70;

endpackage : scc_pkg

// file: scc_regs_sva.sv
// scc_regs_sva: port checks for the control register set.
// assumes a bind onto scc_regs; single clock domain.
`timescale 1ns/100ps
module scc_regs_sva (
  // clock, reset, straps and transfer
  input wire logic        CLK, RST, CP_READ, CP_WRITE, VECTOR_STRAP_INPUT, LOCAL_MEMORY_STRAP_INPUT,
  input wire logic [3:0]  CP_CRN,
  input wire logic [2:0]  CP_OP2,
  input wire logic [31:0] CP_WDATA, CP_RDATA,
  // read valid and control outputs
  input wire logic        CP_RVALID, COMPACT_LOAD_DISABLE, HIGH_VECTORS, INSTR_MEM_ENABLE,
  input wire logic        BIG_ENDIAN, WRITE_BUFFER_ENABLE, DATA_MEM_ENABLE, ALIGN_CHECK_ENABLE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  wire rd0 = CP_READ && CP_CRN == 4'h0;
  wire wr1 = CP_WRITE && CP_CRN == 4'h1;
  wire [3:0] plain = {COMPACT_LOAD_DISABLE, BIG_ENDIAN, WRITE_BUFFER_ENABLE, ALIGN_CHECK_ENABLE};
  rvalid_pulse_a: assert property (CP_RVALID == $past(CP_READ))
    else $error("read answer not one cycle later");
  id_read_a: assert property (rd0 && CP_OP2 != 3'h2 |=> CP_RDATA == 32'h5a00_1230)
    else $error("identification word wrong");
  size_read_a: assert property (rd0 && CP_OP2 == 3'h2 |=> CP_RDATA == 32'h0010_0100)
    else $error("size word wrong");
  reserved_read_a: assert property (CP_READ && CP_CRN > 4'h1 |=> CP_RDATA == 32'h0)
    else $error("reserved register read not zero");
  ctrl_fixed_a: assert property (CP_READ && CP_CRN == 4'h1 |=> (CP_RDATA & 32'hffff_4f71) == 32'h0f70)
    else $error("reserved control bits wrong");
  ctrl_write_a: assert property (wr1 |=> plain == {$past(CP_WDATA[15]), $past(CP_WDATA[7]),
    $past(CP_WDATA[3]), $past(CP_WDATA[1])}) else $error("control write not taken");
  strap_write_a: assert property (wr1 |=> {HIGH_VECTORS, INSTR_MEM_ENABLE, DATA_MEM_ENABLE} ==
    {$past(CP_WDATA[13]), $past(CP_WDATA[12]), $past(CP_WDATA[2])}) else $error("strap bit write not taken");
  ctrl_hold_a: assert property (!wr1 |=> $stable(plain))
    else $error("control bit changed without write");
  strap_load_a: assert property ($fell(RST) |=> HIGH_VECTORS == VECTOR_STRAP_INPUT &&
    INSTR_MEM_ENABLE == LOCAL_MEMORY_STRAP_INPUT && DATA_MEM_ENABLE == LOCAL_MEMORY_STRAP_INPUT)
    else $error("strap not loaded at reset release");
endmodule // scc_regs_sva

// file: scc_core_model.sv
// scc_core_model: core side issuing coprocessor transfers.
// assumes the register set answers one cycle after a read.
`timescale 1ns/100ps
module scc_core_model (
  input  wire logic        CLK,
  output logic             CP_READ, CP_WRITE,
  output logic      [3:0]  CP_CRN,
  output logic      [2:0]  CP_OP2,
  output logic      [31:0] CP_WDATA,
  input  wire logic [31:0] CP_RDATA
);
  initial {CP_READ, CP_WRITE, CP_CRN, CP_OP2, CP_WDATA} = '0;
  task automatic xfer(logic w, logic [3:0] c, logic [2:0] o, logic [31:0] d, output logic [31:0] q);
    @(posedge CLK) #1;
    {CP_READ, CP_WRITE, CP_CRN, CP_OP2, CP_WDATA} = {!w, w, c, o, d};
    @(posedge CLK) #1;
    q = CP_RDATA;
    {CP_READ, CP_WRITE} = 2'h0;
    // idle bus never shows the last register number or write data; the secondary opcode keeps its value
    {CP_CRN, CP_WDATA} = ~{CP_CRN, CP_WDATA};
  endtask
endmodule // scc_core_model

// file: tb_top.sv
// tb_top: drives the control register set through the core model.
// assumes design, model and checker compiled first.
`timescale 1ns/100ps
module tb_top;
  logic CLK = 0, RST = 1, vec = 1, mem = 1, CP_READ, CP_WRITE;
  logic [3:0] CP_CRN;
  logic [2:0] CP_OP2;
  logic [31:0] CP_WDATA, CP_RDATA, q;
  int n_fail = 0, n_compared = 0;
  always #5 CLK = ~CLK;
  scc_regs i_scc_regs (.CLK, .RST, .VECTOR_STRAP_INPUT(vec), .LOCAL_MEMORY_STRAP_INPUT(mem), .CP_READ,
    .CP_WRITE, .CP_CRN, .CP_OP2, .CP_WDATA, .CP_RDATA, .CP_RVALID(), .COMPACT_LOAD_DISABLE(), .HIGH_VECTORS(),
    .INSTR_MEM_ENABLE(), .BIG_ENDIAN(), .WRITE_BUFFER_ENABLE(), .DATA_MEM_ENABLE(), .ALIGN_CHECK_ENABLE());
  scc_core_model i_scc_core_model (.CLK, .CP_READ, .CP_WRITE, .CP_CRN, .CP_OP2, .CP_WDATA, .CP_RDATA);
  task automatic rd(logic [3:0] c, logic [2:0] o, logic [31:0] e);
    i_scc_core_model.xfer(0, c, o, 0, q);
    n_compared++;
    if (q !== e) begin
      n_fail++;
      $display("CHECK FAILED reg %0d op %0d exp %h got %h", c, o, e, q);
    end
  endtask
  task automatic wr(logic [3:0] c, logic [31:0] d);
    i_scc_core_model.xfer(1, c, 0, d, q);
  endtask
  task automatic rst_pulse;
    RST = 1;
    repeat (2) @(posedge CLK);
    #1 RST = 0;
  endtask
  task automatic conclude;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    rst_pulse;
    rd(1, 0, 32'h0000_3f74);
    for (int o = 0; o < 8; o++) rd(0, o[2:0], o == 2 ? 32'h0010_0100 : 32'h5a00_1230);
    for (int c = 2; c < 16; c++) rd(c[3:0], 0, 0);
    wr(1, 32'h0000_bffe);
    wr(5, 0);
    rd(1, 0, 32'h0000_bffe);
    wr(1, 32'h0000_0f70);
    rd(1, 0, 32'h0000_0f70);
    {vec, mem} = 2'h0;
    rst_pulse;
    rd(1, 0, 32'h0000_0f70);
    conclude;
  end
  initial begin
    #20000 n_fail++;
    conclude;
  end
endmodule // tb_top
bind scc_regs scc_regs_sva i_scc_regs_sva (.*);
